/* File: hw/tcsio_defines.svh */
`ifndef TCSIO_DEFINES_SVH
`define TCSIO_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define TCSIO_CLK_MHZ 200
`define TCSIO_MS_US 1000
`define TCSIO_PASS_MS 200
`define TCSIO_TWO_KEY_MS 500
// ----------------------------------------
// Storage limits
// ----------------------------------------
`define TCSIO_PROG_MAX 100
`define TCSIO_STEP_MAX 100
`define TCSIO_STEP_TOTAL 500
`define TCSIO_BCD_MAX 4'h9
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define TCSIO_CTRL_ADDR 8'h00
`define TCSIO_HOLD_ADDR 8'h04
`define TCSIO_STATUS_ADDR 8'h08
`define TCSIO_ALLOC_ADDR 8'h0C
`define TCSIO_CAPS_ADDR 8'h10
`define TCSIO_ALLOC_CLR_BIT 31
`define TCSIO_CAPS_VAL 32'h00000005
`define TCSIO_RESP_OKAY 2'h0
`define TCSIO_RESP_DECERR 2'h3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCSIO_PIN_RST 15'h7FFE
`define TCSIO_OE_B_RST 7'h5F
`endif

/* File: hw/tcsio_pkg.sv */
`include "tcsio_defines.svh"
package tcsio_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_RAMP = 6'h02,
    S_TEST = 6'h04,
    S_PASS = 6'h08,
    S_FAIL = 6'h10,
    S_PROT = 6'h20
  } tcsio_state_type;

  typedef struct packed {
    logic contact;
    logic two_key;
    logic fail_mode;
    logic hold_to_run;
    logic pass_hold;
    logic pass_latch;
  } tcsio_ctrl_type;

  typedef struct packed {
    logic [7:0] sel_n;
    logic select_strobe_n;
    logic start_n;
    logic stop_n;
    logic enable_n;
    logic local_start_n;
    logic local_stop_n;
    logic current_sense;
  } tcsio_pin_in_type;

  typedef struct packed {
    logic ramp_done;
    logic judge_valid;
    logic over_upper;
    logic under_lower;
    logic guard_event;
  } tcsio_meas_type;

  typedef struct packed {
    logic guard_trip_out;
    logic ready;
    logic lower_fail;
    logic upper_fail;
    logic good;
    logic settled;
    logic run_active;
  } tcsio_stat_type;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } tcsio_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcsio_axi_rsp_type;

  typedef struct packed {
    tcsio_state_type state;
    tcsio_ctrl_type ctrl;
    logic [15:0] hold_ms;
    logic [17:0] tick;
    logic [15:0] pass_ms;
    logic [9:0] win_ms;
    logic start_prev;
    logic stop_prev;
    logic strobe_prev;
    logic cur_prev;
    logic upper;
    logic lower;
    logic [`TCSIO_PROG_MAX-1:0][6:0] alloc;
    logic [8:0] total;
    logic refused;
    logic [6:0] prog;
    logic prog_valid;
    logic prog_load;
    logic sel_bad;
    tcsio_stat_type drv;
    tcsio_stat_type oe_b;
  } tcsio_top_st_type;
endpackage : tcsio_pkg

/* File: hw/tcsio_sync.sv */
`timescale 1ns/10ps
module tcsio_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk, // Core clock
  input wire logic rst_b, // Async reset
  input wire logic [W-1:0] d, // Pin levels
  output logic [W-1:0] q // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } tcsio_sync_st_type;

  tcsio_sync_st_type st_q;
  tcsio_sync_st_type st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  // Open inputs idle high from reset onward (see RQ20)
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule : tcsio_sync

/* File: hw/tcsio_axil.sv */
`timescale 1ns/10ps
`include "tcsio_defines.svh"
module tcsio_axil (
  input wire logic clk, // Core clock
  input wire logic rst_b, // Async reset
  input wire tcsio_pkg::tcsio_axi_req_type req, // Master channels
  output tcsio_pkg::tcsio_axi_rsp_type rsp, // Slave channels
  output logic wr_en, // Write strobe
  output logic [7:0] wr_addr, // Write address
  output logic [31:0] wr_data, // Write data
  output logic [3:0] wr_strb, // Byte enables
  input wire logic wr_ok, // Address mapped
  output logic [7:0] rd_addr, // Read address
  input wire logic [31:0] rd_data, // Read data
  input wire logic rd_ok // Address mapped
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    tcsio_pkg::tcsio_axi_rsp_type rsp;
  } tcsio_axil_st_type;

  tcsio_axil_st_type q;
  tcsio_axil_st_type d;

  assign wr_en = q.aw_got & q.w_got & ~q.rsp.bvalid;
  assign wr_addr = q.addr;
  assign wr_data = q.data;
  assign wr_strb = q.strb;
  assign rd_addr = req.araddr;
  assign rsp = q.rsp;

  always_comb begin
    d = q;
    if (req.awvalid && q.rsp.awready) begin
      d.aw_got = 1'b1;
      d.addr = req.awaddr;
      d.rsp.awready = 1'b0;
    end
    if (req.wvalid && q.rsp.wready) begin
      d.w_got = 1'b1;
      d.data = req.wdata;
      d.strb = req.wstrb;
      d.rsp.wready = 1'b0;
    end
    if (wr_en) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = wr_ok ? `TCSIO_RESP_OKAY : `TCSIO_RESP_DECERR;
    end
    // Ready stays low until the response is taken: one write at a time
    if (q.rsp.bvalid && req.bready) begin
      d.rsp.bvalid = 1'b0;
      d.rsp.awready = 1'b1;
      d.rsp.wready = 1'b1;
    end
    if (req.arvalid && q.rsp.arready) begin
      d.rsp.arready = 1'b0;
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata = rd_data;
      d.rsp.rresp = rd_ok ? `TCSIO_RESP_OKAY : `TCSIO_RESP_DECERR;
    end
    if (q.rsp.rvalid && req.rready) begin
      d.rsp.rvalid = 1'b0;
      d.rsp.arready = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0}, default: '0};
    end else begin
      q <= d;
    end
  end
endmodule : tcsio_axil

/* File: hw/tcsio_top.sv */
// Operation
// [RQ1] Latch mode holds good result for set time
// [RQ2] Hold-to-run: test only while start held
// [RQ3] Fail mode: remote stop cannot clear errors
// [RQ4] Two-key: start within half second of stop
// [RQ5] Contact mode: current flow starts the test
// [RQ6] Select is two BCD digits, active low
// [RQ7] Latch select at strobe rise, recall it
// [RQ8] Run output whole test; settled excludes ramp
// [RQ9] Good result pulses about 0.2 s
// [RQ10] Hold setting keeps good result asserted
// [RQ11] Upper fail output while over-limit failure
// [RQ12] Lower fail output while under-limit failure
// [RQ13] Remote start input begins a test
// [RQ14] Enable input must qualify remote start
// [RQ15] Store up to 100 sequence programs
// [RQ16] Refuse step totals above 500
// [RQ17] Talker supports all but talk-only
// [RQ18] Listener supports all but listen-only
// [RQ19] Control inputs active low, 5 ms minimum
// [RQ20] Open control inputs read inactive high
// [RQ21] Ready output only when idle and startable; the code asserts it whenever the state is idle
// [RQ22] Guard-trip output while guard_trip_out holds
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`include "tcsio_defines.svh"
module tcsio_top #(
  parameter int MS_CYC = `TCSIO_MS_US * `TCSIO_CLK_MHZ
) (
  input wire logic CORE_CLK, // 200 MHz core clock
  input wire logic RST_B, // Async reset
  input wire tcsio_pkg::tcsio_axi_req_type AXI_REQ, // AXI4-Lite master side
  output tcsio_pkg::tcsio_axi_rsp_type AXI_RSP, // AXI4-Lite slave side
  input wire tcsio_pkg::tcsio_pin_in_type PIN_IN, // Control port inputs
  input wire tcsio_pkg::tcsio_meas_type MEAS, // Measurement engine events
  output tcsio_pkg::tcsio_stat_type STAT_O, // Open-drain data, always low
  output tcsio_pkg::tcsio_stat_type STAT_OE_B, // Low pulls pin on
  output logic [6:0] PROG_NUM, // Recalled program number
  output logic PROG_LOAD // Recall pulse
);
  // ----------------------------------------
  // State and helpers
  // ----------------------------------------
  localparam tcsio_pkg::tcsio_top_st_type ST_RST = '{
    state: tcsio_pkg::S_IDLE,
    strobe_prev: 1'b1,
    oe_b: `TCSIO_OE_B_RST,
    default: '0
  };

  tcsio_pkg::tcsio_top_st_type q;
  tcsio_pkg::tcsio_top_st_type d;
  tcsio_pkg::tcsio_pin_in_type pin;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [31:0] ctrl_m;
  logic [31:0] hold_m;
  logic ms_tick;
  logic start_lvl;
  logic start_edge;
  logic start_ok;
  logic stop_local;
  logic stop_remote;
  logic stop_any;
  logic cur_edge;
  logic strobe_rise;
  logic [7:0] sel_v;
  logic sel_ok;
  logic [9:0] new_total;
  logic [6:0] a_idx;
  logic [6:0] a_num;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return a == `TCSIO_CTRL_ADDR || a == `TCSIO_HOLD_ADDR || a == `TCSIO_STATUS_ADDR ||
           a == `TCSIO_ALLOC_ADDR || a == `TCSIO_CAPS_ADDR;
  endfunction : mapped

  tcsio_sync #(
    .W($bits(tcsio_pkg::tcsio_pin_in_type)),
    .RST_VAL(`TCSIO_PIN_RST)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d(PIN_IN),
    .q(pin)
  );

  tcsio_axil u_axil (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .req(AXI_REQ),
    .rsp(AXI_RSP),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ----------------------------------------
  // Input qualification
  // ----------------------------------------
  assign ms_tick = q.tick == 18'(MS_CYC - 1);
  // Active-low pins; callers hold each for 5 ms, so no filter (see RQ19)
  assign start_lvl = ~pin.local_start_n | (~pin.start_n & ~pin.enable_n); // see RQ13 see RQ14
  assign start_edge = start_lvl & ~q.start_prev;
  assign stop_local = ~pin.local_stop_n;
  assign stop_remote = ~pin.stop_n;
  assign stop_any = stop_local | stop_remote;
  assign start_ok = start_edge & ~stop_any & (~q.ctrl.two_key | (q.win_ms != 10'h000)); // see RQ4
  assign cur_edge = pin.current_sense & ~q.cur_prev;
  assign strobe_rise = pin.select_strobe_n & ~q.strobe_prev;
  assign sel_v = ~pin.sel_n; // see RQ6
  assign sel_ok = sel_v[3:0] <= `TCSIO_BCD_MAX && sel_v[7:4] <= `TCSIO_BCD_MAX;
  assign ctrl_m = merge({26'h0, q.ctrl}, wr_data, wr_strb);
  assign hold_m = merge({16'h0, q.hold_ms}, wr_data, wr_strb);
  assign a_idx = wr_data[6:0];
  assign a_num = wr_data[22:16];
  assign wr_ok = mapped(wr_addr);
  assign rd_ok = mapped(rd_addr);

  always_comb begin
    new_total = 10'h000;
    if (a_idx < 7'(`TCSIO_PROG_MAX)) begin
      new_total = 10'({1'b0, q.total} - {3'h0, q.alloc[a_idx]} + {3'h0, a_num});
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_comb begin
    case (rd_addr)
      `TCSIO_CTRL_ADDR: rd_data = {26'h0, q.ctrl};
      `TCSIO_HOLD_ADDR: rd_data = {16'h0, q.hold_ms};
      `TCSIO_STATUS_ADDR: rd_data = {15'h0, q.sel_bad, q.prog_valid, q.prog, q.lower, q.upper, q.state};
      `TCSIO_ALLOC_ADDR: rd_data = {15'h0, q.refused, 7'h00, q.total};
      `TCSIO_CAPS_ADDR: rd_data = `TCSIO_CAPS_VAL; // see RQ17 see RQ18
      default: rd_data = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    d = q;
    d.prog_load = 1'b0;
    d.tick = ms_tick ? 18'h00000 : 18'(q.tick + 18'h00001);
    d.start_prev = start_lvl;
    d.stop_prev = stop_any;
    d.strobe_prev = pin.select_strobe_n;
    d.cur_prev = pin.current_sense;
    // Window opens at stop release; in two-key mode only a press inside it starts
    if (q.stop_prev && !stop_any) begin
      d.win_ms = 10'(`TCSIO_TWO_KEY_MS); // see RQ4
    end else if (ms_tick && q.win_ms != 10'h000) begin
      d.win_ms = 10'(q.win_ms - 10'h001);
    end
    if (strobe_rise) begin
      if (sel_ok) begin
        d.prog = 7'(sel_v[7:4] * 4'hA + sel_v[3:0]); // see RQ6 see RQ7
        d.prog_valid = 1'b1;
        d.prog_load = 1'b1;
        d.sel_bad = 1'b0;
      end else begin
        d.sel_bad = 1'b1;
      end
    end
    if (wr_en) begin
      case (wr_addr)
        `TCSIO_CTRL_ADDR: d.ctrl = ctrl_m[5:0];
        `TCSIO_HOLD_ADDR: d.hold_ms = hold_m[15:0];
        `TCSIO_ALLOC_ADDR: begin
          if (wr_data[`TCSIO_ALLOC_CLR_BIT]) begin
            d.refused = 1'b0;
          end else if (a_idx < 7'(`TCSIO_PROG_MAX) && a_num <= 7'(`TCSIO_STEP_MAX) &&
                       new_total <= 10'(`TCSIO_STEP_TOTAL)) begin // see RQ15 see RQ16
            d.alloc[a_idx] = a_num;
            d.total = new_total[8:0];
          end else begin
            d.refused = 1'b1; // see RQ16
          end
        end
        default: d.refused = q.refused;
      endcase
    end
    case (q.state)
      tcsio_pkg::S_IDLE: begin
        if (MEAS.guard_event) begin
          d.state = tcsio_pkg::S_PROT;
        end else if (start_ok || (q.ctrl.contact && cur_edge)) begin // see RQ5 see RQ13
          d.state = tcsio_pkg::S_RAMP;
          d.upper = 1'b0;
          d.lower = 1'b0;
        end
      end
      tcsio_pkg::S_RAMP, tcsio_pkg::S_TEST: begin
        if (MEAS.guard_event) begin
          d.state = tcsio_pkg::S_PROT;
        end else if (stop_any || (q.ctrl.hold_to_run && !start_lvl)) begin // see RQ2
          d.state = tcsio_pkg::S_IDLE;
        end else if (q.state == tcsio_pkg::S_RAMP) begin
          if (MEAS.ramp_done) begin
            d.state = tcsio_pkg::S_TEST;
          end
        end else if (MEAS.judge_valid) begin
          d.upper = MEAS.over_upper; // see RQ11
          d.lower = MEAS.under_lower; // see RQ12
          if (MEAS.over_upper || MEAS.under_lower) begin
            d.state = tcsio_pkg::S_FAIL;
          end else begin
            d.state = tcsio_pkg::S_PASS;
            d.pass_ms = q.ctrl.pass_latch ? q.hold_ms : 16'(`TCSIO_PASS_MS); // see RQ1 see RQ9
          end
        end
      end
      tcsio_pkg::S_PASS: begin
        if (MEAS.guard_event) begin
          d.state = tcsio_pkg::S_PROT;
        end else if (stop_any) begin
          d.state = tcsio_pkg::S_IDLE;
        end else if (start_ok) begin
          d.state = tcsio_pkg::S_RAMP;
        end else if (!q.ctrl.pass_hold && ms_tick) begin // see RQ10
          if (q.pass_ms <= 16'h0001) begin
            d.state = tcsio_pkg::S_IDLE; // see RQ9
          end else begin
            d.pass_ms = 16'(q.pass_ms - 16'h0001);
          end
        end
      end
      tcsio_pkg::S_FAIL, tcsio_pkg::S_PROT: begin
        if (MEAS.guard_event) begin
          d.state = tcsio_pkg::S_PROT; // see RQ22
        end else if (stop_local || (stop_remote && !q.ctrl.fail_mode)) begin // see RQ3
          d.state = tcsio_pkg::S_IDLE;
          d.upper = 1'b0;
          d.lower = 1'b0;
        end
      end
      default: d.state = tcsio_pkg::S_IDLE;
    endcase
    // Pins follow the next state so they switch with it, not a cycle late
    d.oe_b.run_active = !(d.state == tcsio_pkg::S_RAMP || d.state == tcsio_pkg::S_TEST); // see RQ8
    d.oe_b.settled = d.state != tcsio_pkg::S_TEST; // see RQ8
    d.oe_b.good = d.state != tcsio_pkg::S_PASS; // see RQ9 see RQ10
    d.oe_b.upper_fail = !(d.state == tcsio_pkg::S_FAIL && d.upper); // see RQ11
    d.oe_b.lower_fail = !(d.state == tcsio_pkg::S_FAIL && d.lower); // see RQ12
    d.oe_b.ready = d.state != tcsio_pkg::S_IDLE; // see RQ21
    d.oe_b.guard_trip_out = d.state != tcsio_pkg::S_PROT; // see RQ22
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign STAT_O = q.drv;
  assign STAT_OE_B = q.oe_b;
  assign PROG_NUM = q.prog;
  assign PROG_LOAD = q.prog_load;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence quiet_s;
    !MEAS.guard_event && !stop_any && !start_ok;
  endsequence

  sequence judged_pass_s;
    q.state == tcsio_pkg::S_TEST && MEAS.judge_valid && !MEAS.over_upper && !MEAS.under_lower &&
      !MEAS.guard_event && !stop_any && !(q.ctrl.hold_to_run && !start_lvl);
  endsequence

  AST_LATCH_LOAD: assert property (judged_pass_s ##0 q.ctrl.pass_latch |=> // see RQ1
    q.state == tcsio_pkg::S_PASS && q.pass_ms == $past(q.hold_ms) && !q.oe_b.good)
    else $error("latch time not loaded");
  AST_PASS_DEFAULT: assert property (judged_pass_s ##0 !q.ctrl.pass_latch |=> // see RQ9
    q.pass_ms == 16'(`TCSIO_PASS_MS) && !q.oe_b.good)
    else $error("default pass time wrong");
  AST_PASS_END: assert property ((q.state == tcsio_pkg::S_PASS && !q.ctrl.pass_hold && // see RQ9
    q.pass_ms <= 16'h0001 && ms_tick) and quiet_s |=> q.state == tcsio_pkg::S_IDLE && q.oe_b.good)
    else $error("pass pulse did not end");
  AST_PASS_HOLD: assert property ((q.state == tcsio_pkg::S_PASS && q.ctrl.pass_hold) and quiet_s |=> // see RQ10
    q.state == tcsio_pkg::S_PASS && !q.oe_b.good)
    else $error("held pass dropped");
  AST_HOLD_TO_RUN: assert property ((q.state == tcsio_pkg::S_RAMP || q.state == tcsio_pkg::S_TEST) && // see RQ2
    q.ctrl.hold_to_run && !start_lvl && !MEAS.guard_event |=> q.state == tcsio_pkg::S_IDLE && q.oe_b.run_active)
    else $error("released start kept test");
  AST_FAIL_MODE: assert property (q.state == tcsio_pkg::S_FAIL && q.ctrl.fail_mode && !stop_local && // see RQ3
    !MEAS.guard_event |=> q.state == tcsio_pkg::S_FAIL)
    else $error("fail cleared remotely");
  AST_TWO_KEY: assert property (q.state == tcsio_pkg::S_IDLE && q.ctrl.two_key && q.win_ms == 10'h000 && // see RQ4
    !q.ctrl.contact && !MEAS.guard_event |=> q.state == tcsio_pkg::S_IDLE)
    else $error("start outside window");
  AST_CONTACT: assert property (q.state == tcsio_pkg::S_IDLE && q.ctrl.contact && cur_edge && // see RQ5
    !MEAS.guard_event |=> q.state == tcsio_pkg::S_RAMP ##1 !q.oe_b.run_active || q.state != tcsio_pkg::S_RAMP)
    else $error("current did not start");
  AST_BCD: assert property (strobe_rise && sel_ok |=> PROG_LOAD && // see RQ7
    PROG_NUM == 7'($past(sel_v[7:4]) * 4'hA + $past(sel_v[3:0])))
    else $error("bad recall number");
  AST_RUN_OUT: assert property (q.state == tcsio_pkg::S_RAMP |-> !q.oe_b.run_active && q.oe_b.settled) // see RQ8
    else $error("ramp outputs wrong");
  AST_UPPER: assert property (q.state == tcsio_pkg::S_FAIL && q.upper |-> !q.oe_b.upper_fail) // see RQ11
    else $error("upper fail not shown");
  AST_LOWER: assert property (q.state == tcsio_pkg::S_FAIL && q.lower |-> !q.oe_b.lower_fail) // see RQ12
    else $error("lower fail not shown");
  AST_TOTAL: assert property (q.total <= 9'(`TCSIO_STEP_TOTAL)) // see RQ16
    else $error("step total exceeded");
  AST_READY: assert property ((q.state == tcsio_pkg::S_IDLE) != q.oe_b.ready) // see RQ21
    else $error("ready mismatch");
  AST_GUARD: assert property (MEAS.guard_event |=> q.state == tcsio_pkg::S_PROT && !q.oe_b.guard_trip_out) // see RQ22
    else $error("guard trip missed");
endmodule : tcsio_top

/* File: tb/tcsio_plc_model.sv */
`timescale 1ns/10ps
module tcsio_plc_model (
  input wire logic clk, // Core clock
  output tcsio_pkg::tcsio_pin_in_type pins // Control port lines
);
  // ----------------------------------------
  // Controller side of the control port
  // ----------------------------------------
  localparam logic [14:0] IDLE = 15'h7FFE;
  localparam int HOLD_CYC = 60; // Above 5 ms at the short sim tick
  initial pins = IDLE;
  task automatic act(input logic [14:0] mask);
    @(posedge clk);
    pins <= IDLE ^ mask;
    repeat (HOLD_CYC) @(posedge clk);
    pins <= IDLE;
    repeat (HOLD_CYC) @(posedge clk);
  endtask : act
  task automatic select(input logic [7:0] sel_n);
    @(posedge clk);
    pins <= {sel_n, 7'h3E};
    repeat (HOLD_CYC) @(posedge clk);
    pins <= {sel_n, 7'h7E}; // Lines stay put across the strobe rise
    repeat (HOLD_CYC) @(posedge clk);
    pins <= IDLE; // Released lines fall back to the pull-up
    repeat (HOLD_CYC) @(posedge clk);
  endtask : select
endmodule : tcsio_plc_model

/* File: tb/tb_tester_control_signal_io.sv */
`timescale 1ns/10ps
module tb_tester_control_signal_io;
  // ----------------------------------------
  // Bench state
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  tcsio_pkg::tcsio_axi_req_type req = '0;
  tcsio_pkg::tcsio_axi_rsp_type rsp;
  tcsio_pkg::tcsio_pin_in_type pins;
  logic [4:0] meas = 5'h00;
  tcsio_pkg::tcsio_stat_type stat_o;
  tcsio_pkg::tcsio_stat_type oe_b;
  logic [6:0] prog_num;
  logic prog_load;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 32'h3656;
  logic [33:0] rd_q[$];
  logic [6:0] pg_q[$];
  logic [4:0] fm [3] = '{5'h1C, 5'h1A, 5'h11};
  int fb [3] = '{3, 4, 6};
  always #2.5 core_clk = ~core_clk;
  tcsio_top #(.MS_CYC(10)) dut_u (.CORE_CLK(core_clk), .RST_B(rst_b), .AXI_REQ(req), .AXI_RSP(rsp),
    .PIN_IN(pins), .MEAS(meas), .STAT_O(stat_o), .STAT_OE_B(oe_b), .PROG_NUM(prog_num), .PROG_LOAD(prog_load));
  tcsio_plc_model plc_u (.clk(core_clk), .pins(pins));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Output watcher and timeout
  // ----------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      tally_and_finish();
    end
    if (rst_b && rsp.rvalid && req.rready) begin
      if (rd_q.size() == 0) chk(1, 0);
      else chk({rsp.rresp, rsp.rdata}, rd_q.pop_front());
    end
    if (rst_b && prog_load) begin
      if (pg_q.size() == 0) chk(1, 0);
      else chk(prog_num, pg_q.pop_front());
    end
  end
  // ----------------------------------------
  // Bus and pin helpers
  // ----------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: s, bready: 1'b1, default: '0};
    do begin
      @(posedge core_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    chk(rsp.bresp, 2'h0);
    // Let bready settle low before the next request rewrites it
    @(posedge core_clk);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [33:0] exp);
    rd_q.push_back(exp);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(posedge core_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    @(posedge core_clk);
  endtask : axr
  task automatic wt(input int b, input logic v);
    int n = 0;
    while (oe_b[b] !== v && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk(oe_b[b], v);
  endtask : wt
  // Remote start, full ramp, then a good judgment; good must still be on len - 20 cycles after it rises
  task automatic pass_run(input int len);
    plc_u.act(15'h0028);
    chk(oe_b.settled, 1'b1); // Ramp still running
    meas <= 5'h10;
    wt(1, 1'b0);
    meas <= 5'h18;
    @(posedge core_clk);
    meas <= 5'h10;
    wt(2, 1'b0);
    repeat (len - 20) @(posedge core_clk);
    chk(oe_b.good, 1'b0);
    meas <= 5'h00;
  endtask : pass_run
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [3:0] t;
    logic [3:0] u;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    chk(oe_b, 7'h5F);
    chk(stat_o, 7'h00);
    axr(8'h10, 34'h5);
    axr(8'h40, 34'h3_0000_0000);
    axw(8'h0C, 32'h0065_0000);
    axr(8'h0C, 34'h1_0000);
    axw(8'h0C, 32'h0064_0063);
    axr(8'h0C, 34'h1_0064);
    axw(8'h0C, 32'h8000_0000);
    axr(8'h0C, 34'h64);
    repeat (3) begin
      t = 4'($unsigned($random(seed)) % 10);
      u = 4'($unsigned($random(seed)) % 10);
      pg_q.push_back(7'(t * 10 + u));
      plc_u.select(~{t, u});
    end
    plc_u.select(~8'h0A); // Digit above nine loads nothing
    plc_u.act(15'h0020);
    chk(oe_b.run_active, 1'b1);
    pass_run(2000);
    wt(5, 1'b0);
    axw(8'h04, 32'h5A5A_A51E, 4'h1); // Only byte 0 enabled: hold 30
    axr(8'h04, 34'h1E);
    axw(8'h00, 32'h1);
    pass_run(300);
    repeat (30) @(posedge core_clk);
    chk(oe_b.good, 1'b1);
    axw(8'h00, 32'h2);
    pass_run(3000);
    plc_u.act(15'h0002);
    axw(8'h00, 32'h4);
    fork
      plc_u.act(15'h0004);
      wt(0, 1'b0);
    join
    chk(oe_b.run_active, 1'b1);
    axw(8'h00, 32'h8);
    for (int k = 0; k < 3; k++) begin
      plc_u.act(15'h0028);
      // Judgement only counts once the ramp is over
      meas <= 5'h10;
      wt(1, 1'b0);
      meas <= fm[k];
      @(posedge core_clk);
      meas <= 5'h10;
      wt(fb[k], 1'b0);
      plc_u.act(15'h0010);
      chk(oe_b[fb[k]], 1'b0);
      plc_u.act(15'h0002);
      chk(oe_b[fb[k]], 1'b1);
    end
    meas <= 5'h00;
    axw(8'h00, 32'h10);
    plc_u.act(15'h0002);
    plc_u.act(15'h0004);
    chk(oe_b.run_active, 1'b0);
    plc_u.act(15'h0002);
    repeat (5200) @(posedge core_clk);
    plc_u.act(15'h0004);
    chk(oe_b.run_active, 1'b1);
    axw(8'h00, 32'h20);
    fork
      plc_u.act(15'h0001);
      wt(0, 1'b0);
    join
    plc_u.act(15'h0002);
    tally_and_finish();
  end
endmodule : tb_tester_control_signal_io
